// ### rtl/dtc_defines.svh
// Constants of the four-channel transfer engine: register map, fields, address regions.
// Assumes a 25 MHz core_clk and an APB master with 32-bit data.
// Overview of operation
// - Transfer is source read then destination write.
// - Odd 16-bit source read takes extra cycle.
// - Odd 16-bit destination write takes extra cycle.
// - Byte bus both ends: two reads, two writes.
// - Byte source, word destination: two reads, one write.
// - Word source, byte destination: one read, two writes.
// - Area width bit zero selects byte bus.
// - Width effects only for external expansion accesses.
// - Software wait states lengthen internal non-SFR accesses only.
// - External access stretched while ready-extension held.
// - Cycles equal reads times j plus writes times k.
// - External j,k: bus timing plus recovery cycle.
// - Same-period requests set flags together.
// - Channel 0 first, then 1, 2, 3.
// - Bus returns to CPU between channel transfers.
// - One merging flag per channel, cleared at grant.
// - Each grant moves exactly one unit.
// - Unit select zero byte, one halfword.
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH

// Register byte offsets.
`define DTC_OFF_CFG        8'h00
`define DTC_OFF_SWREQ      8'h04
`define DTC_OFF_STATUS     8'h08
`define DTC_OFF_ADDR_BASE  8'h10
`define DTC_OFF_ADDR_LAST  8'h2c

// Configuration register fields and reset value.
`define DTC_CFG_EXT_MODE   0
`define DTC_CFG_INT_WAIT   1
`define DTC_CFG_RECOVERY   2
`define DTC_CFG_UNIT_LSB   4
`define DTC_CFG_BUSW_LSB   8
`define DTC_CFG_EXTC_LSB   12
`define DTC_CFG_RESET      16'h2000

// Address regions and external area select.
`define DTC_SFR_LAST       24'h0003ff
`define DTC_INT_LAST       24'h00ffff
`define DTC_AREA_MSB       23
`define DTC_AREA_LSB       22

// Access coefficients in core clocks.
`define DTC_COEF_FAST      4'h1
`define DTC_COEF_SLOW      4'h2

`endif

// ### rtl/dtc_pkg.sv
// Types shared by the transfer engine modules.
// Assumes dtc_defines.svh is on the include path.
package dtc_pkg;

    typedef enum logic [1:0] {DTC_IDLE, DTC_READ, DTC_WRITE} dtc_state_t;

    // Whole state of the engine top.
    typedef struct packed {
        dtc_state_t        state;
        logic [1:0]        chan;
        logic              beat;
        logic [3:0]        cnt;
        logic              need_cpu;
        logic [15:0]       hold;
        logic [15:0]       cfg;
        logic [3:0][23:0]  src;
        logic [3:0][23:0]  dst;
        logic [7:0]        last_cycles;
        logic              unit16;
        logic [1:0]        r_n;
        logic [3:0]        r_coef;
        logic              r_ext;
        logic              r_split;
        logic [1:0]        w_n;
        logic [3:0]        w_coef;
        logic              w_ext;
        logic              w_split;
        logic              owns_bus;
        logic [23:0]       mem_addr;
        logic              mem_rd;
        logic              mem_wr;
        logic              mem_byte;
        logic [15:0]       mem_wdata;
        logic [31:0]       prdata;
        logic              pready;
        logic              pslverr;
    } dtc_core_st_t;

    // State of one request flag.
    typedef struct packed {
        logic flag;
    } dtc_flag_st_t;

endpackage

// ### rtl/dtc_req_flag.sv
// One channel request flag with merging sets and a clear at grant.
// Assumes set and clear are synchronous to core_clk.
module dtc_req_flag (
    input  wire logic core_clk,
    input  wire logic resetn,
    input  wire logic set,
    input  wire logic clear,
    output logic      flag
);

    dtc_pkg::dtc_flag_st_t st_r;
    dtc_pkg::dtc_flag_st_t st_nxt;

    // A request in the grant cycle survives, so no event is lost.
    always_comb
    begin
        st_nxt = st_r;
        if (set)
        begin
            st_nxt.flag = 1'b1;
        end
        else if (clear)
        begin
            st_nxt.flag = 1'b0;
        end
    end

    // State register.
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign flag = st_r.flag;

endmodule

// ### rtl/dtc_access_plan.sv
// Works out bus cycles and clock coefficient for one side of a transfer.
// Purely combinational; the caller latches the results at grant.
`include "dtc_defines.svh"
module dtc_access_plan (
    input  wire logic [23:0] addr,
    input  wire logic        unit16,
    input  wire logic        ext_mode,
    input  wire logic [3:0]  busw,
    input  wire logic        int_wait,
    input  wire logic        recovery,
    input  wire logic [3:0]  ext_cyc,
    output logic [1:0]       n_cyc,
    output logic [3:0]       coef,
    output logic             is_ext,
    output logic             split
);

    logic [1:0] area;
    logic       wide;

    // Region decode, width choice and coefficient.
    always_comb
    begin
        area   = addr[`DTC_AREA_MSB:`DTC_AREA_LSB];
        is_ext = ext_mode && (addr > `DTC_INT_LAST);
        wide   = is_ext ? busw[area] : 1'b1;
        if (!unit16)
        begin
            n_cyc = 2'h1;
        end
        else if (!wide || addr[0])
        begin
            n_cyc = 2'h2;
        end
        else
        begin
            n_cyc = 2'h1;
        end
        split = unit16 && (n_cyc == 2'h2);
        if (is_ext)
        begin
            coef = ext_cyc + {3'h0, recovery};
        end
        else if (addr <= `DTC_SFR_LAST || int_wait)
        begin
            coef = `DTC_COEF_SLOW;
        end
        else
        begin
            coef = `DTC_COEF_FAST;
        end
    end

endmodule

// ### rtl/dtc_core.sv
// Four-channel transfer engine: request flags, fixed-priority arbiter, bus
// cycle sequencer and APB register file.
// Assumes the CPU pulses cpu_access_done after each of its own bus accesses and
// that the memory bus answers within the counted cycles unless stretched.
`include "dtc_defines.svh"
module dtc_core (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [3:0]  dma_request,
    input  wire logic        cpu_access_done,
    input  wire logic        ext_wait_hold,
    input  wire logic [15:0] mem_rdata,
    output logic             dma_owns_bus,
    output logic [23:0]      mem_addr,
    output logic             mem_rd,
    output logic             mem_wr,
    output logic             mem_byte,
    output logic [15:0]      mem_wdata
);

    dtc_pkg::dtc_core_st_t st_r;
    dtc_pkg::dtc_core_st_t st_nxt;

    logic [3:0]  channel_request_flag;
    logic [3:0]  flag_set;
    logic [3:0]  flag_clear;
    logic [3:0]  sw_set;
    logic        wr_take;
    logic        grant;
    logic [1:0]  pick;
    logic [3:0]  transfer_unit_select;
    logic [3:0]  external_bus_width_register;
    logic [1:0]  r_n;
    logic [3:0]  r_coef;
    logic        r_ext;
    logic        r_split;
    logic [1:0]  w_n;
    logic [3:0]  w_coef;
    logic        w_ext;
    logic        w_split;

    assign transfer_unit_select        = st_r.cfg[`DTC_CFG_UNIT_LSB +: 4];
    assign external_bus_width_register = st_r.cfg[`DTC_CFG_BUSW_LSB +: 4];

    // A write is taken on the second access cycle, when pready is already high.
    assign wr_take = psel && penable && pwrite && st_r.pready;
    assign sw_set  = (wr_take && paddr == `DTC_OFF_SWREQ) ? pwdata[3:0] : 4'h0;

    // Fixed priority pick, lowest channel number wins.
    always_comb
    begin
        pick = 2'h0;
        if (channel_request_flag[0])
        begin
            pick = 2'h0;
        end
        else if (channel_request_flag[1])
        begin
            pick = 2'h1;
        end
        else if (channel_request_flag[2])
        begin
            pick = 2'h2;
        end
        else
        begin
            pick = 2'h3;
        end
    end

    // A grant needs an idle engine and a completed CPU access since the last one.
    assign grant = (st_r.state == dtc_pkg::DTC_IDLE) && !st_r.need_cpu
                   && (channel_request_flag != 4'h0);

    // Hardware and software requests land in the same clock.
    assign flag_set   = dma_request | sw_set;
    assign flag_clear = grant ? (4'h1 << pick) : 4'h0;

    // One flag per channel.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_flag
            dtc_req_flag u_flag (
                .core_clk (core_clk),
                .resetn   (resetn),
                .set      (flag_set[gi]),
                .clear    (flag_clear[gi]),
                .flag     (channel_request_flag[gi])
            );
        end
    endgenerate

    // Source side plan for the channel about to be granted.
    dtc_access_plan u_src_plan (
        .addr     (st_r.src[pick]),
        .unit16   (transfer_unit_select[pick]),
        .ext_mode (st_r.cfg[`DTC_CFG_EXT_MODE]),
        .busw     (external_bus_width_register),
        .int_wait (st_r.cfg[`DTC_CFG_INT_WAIT]),
        .recovery (st_r.cfg[`DTC_CFG_RECOVERY]),
        .ext_cyc  (st_r.cfg[`DTC_CFG_EXTC_LSB +: 4]),
        .n_cyc    (r_n),
        .coef     (r_coef),
        .is_ext   (r_ext),
        .split    (r_split)
    );

    // Destination side plan for the same channel.
    dtc_access_plan u_dst_plan (
        .addr     (st_r.dst[pick]),
        .unit16   (transfer_unit_select[pick]),
        .ext_mode (st_r.cfg[`DTC_CFG_EXT_MODE]),
        .busw     (external_bus_width_register),
        .int_wait (st_r.cfg[`DTC_CFG_INT_WAIT]),
        .recovery (st_r.cfg[`DTC_CFG_RECOVERY]),
        .ext_cyc  (st_r.cfg[`DTC_CFG_EXTC_LSB +: 4]),
        .n_cyc    (w_n),
        .coef     (w_coef),
        .is_ext   (w_ext),
        .split    (w_split)
    );

    // Sequencer, register file and APB answer.
    always_comb
    begin
        logic [4:0] idx;
        logic [5:0] rd_part;
        logic [5:0] wr_part;
        st_nxt  = st_r;
        idx     = 5'h0;
        rd_part = 6'h0;
        wr_part = 6'h0;

        // APB: pready rises one cycle into the access phase, for one cycle.
        st_nxt.pready  = psel && penable && !st_r.pready;
        st_nxt.pslverr = 1'b0;
        st_nxt.prdata  = 32'h0000_0000;
        if (psel && penable && !st_r.pready)
        begin
            if (paddr == `DTC_OFF_CFG)
            begin
                st_nxt.prdata = {16'h0000, st_r.cfg};
            end
            else if (paddr == `DTC_OFF_SWREQ)
            begin
                st_nxt.prdata = 32'h0000_0000;
            end
            else if (paddr == `DTC_OFF_STATUS)
            begin
                st_nxt.prdata = {16'h0000, st_r.last_cycles, st_r.chan,
                                 st_r.need_cpu, st_r.owns_bus, channel_request_flag};
            end
            else if (paddr >= `DTC_OFF_ADDR_BASE && paddr <= `DTC_OFF_ADDR_LAST
                     && paddr[1:0] == 2'h0)
            begin
                idx = paddr[6:2] - 5'h4;
                st_nxt.prdata = {8'h00, idx[0] ? st_r.dst[idx[2:1]] : st_r.src[idx[2:1]]};
            end
            else
            begin
                st_nxt.pslverr = 1'b1;
            end
        end
        if (wr_take)
        begin
            if (paddr == `DTC_OFF_CFG)
            begin
                st_nxt.cfg = pwdata[15:0];
            end
            else if (paddr >= `DTC_OFF_ADDR_BASE && paddr <= `DTC_OFF_ADDR_LAST
                     && paddr[1:0] == 2'h0)
            begin
                idx = paddr[6:2] - 5'h4;
                if (idx[0])
                begin
                    st_nxt.dst[idx[2:1]] = pwdata[23:0];
                end
                else
                begin
                    st_nxt.src[idx[2:1]] = pwdata[23:0];
                end
            end
        end

        case (st_r.state)
            dtc_pkg::DTC_IDLE:
            begin
                if (st_r.need_cpu && cpu_access_done)
                begin
                    st_nxt.need_cpu = 1'b0;
                end
                if (grant)
                begin
                    st_nxt.state    = dtc_pkg::DTC_READ;
                    st_nxt.chan     = pick;
                    st_nxt.unit16   = transfer_unit_select[pick];
                    st_nxt.r_n      = r_n;
                    st_nxt.r_coef   = r_coef;
                    st_nxt.r_ext    = r_ext;
                    st_nxt.r_split  = r_split;
                    st_nxt.w_n      = w_n;
                    st_nxt.w_coef   = w_coef;
                    st_nxt.w_ext    = w_ext;
                    st_nxt.w_split  = w_split;
                    st_nxt.beat     = 1'b0;
                    st_nxt.cnt      = r_coef - 4'h1;
                    st_nxt.owns_bus = 1'b1;
                    st_nxt.mem_rd   = 1'b1;
                    st_nxt.mem_addr = st_r.src[pick];
                    st_nxt.mem_byte = r_split || !transfer_unit_select[pick];
                    rd_part = 6'(r_n * r_coef);
                    wr_part = 6'(w_n * w_coef);
                    st_nxt.last_cycles = 8'(rd_part + wr_part);
                end
            end
            dtc_pkg::DTC_READ:
            begin
                if (st_r.cnt != 4'h0)
                begin
                    st_nxt.cnt = st_r.cnt - 4'h1;
                end
                else if (st_r.r_ext && ext_wait_hold)
                begin
                    st_nxt.cnt = 4'h0;
                end
                else
                begin
                    if (!st_r.mem_byte)
                    begin
                        st_nxt.hold = mem_rdata;
                    end
                    else if (st_r.beat)
                    begin
                        st_nxt.hold[15:8] = mem_rdata[7:0];
                    end
                    else
                    begin
                        st_nxt.hold[7:0] = mem_rdata[7:0];
                    end
                    if (!st_r.beat && st_r.r_n == 2'h2)
                    begin
                        st_nxt.beat     = 1'b1;
                        st_nxt.cnt      = st_r.r_coef - 4'h1;
                        st_nxt.mem_addr = st_r.mem_addr + 24'h000001;
                    end
                    else
                    begin
                        st_nxt.state    = dtc_pkg::DTC_WRITE;
                        st_nxt.beat     = 1'b0;
                        st_nxt.cnt      = st_r.w_coef - 4'h1;
                        st_nxt.mem_rd   = 1'b0;
                        st_nxt.mem_wr   = 1'b1;
                        st_nxt.mem_addr = st_r.dst[st_r.chan];
                        st_nxt.mem_byte = st_r.w_split || !st_r.unit16;
                        if (!st_r.mem_byte)
                        begin
                            st_nxt.mem_wdata = mem_rdata;
                        end
                        else if (st_r.beat)
                        begin
                            st_nxt.mem_wdata = st_r.w_split
                                ? {8'h00, st_r.hold[7:0]}
                                : {mem_rdata[7:0], st_r.hold[7:0]};
                        end
                        else
                        begin
                            st_nxt.mem_wdata = {8'h00, mem_rdata[7:0]};
                        end
                    end
                end
            end
            dtc_pkg::DTC_WRITE:
            begin
                if (st_r.cnt != 4'h0)
                begin
                    st_nxt.cnt = st_r.cnt - 4'h1;
                end
                else if (st_r.w_ext && ext_wait_hold)
                begin
                    st_nxt.cnt = 4'h0;
                end
                else if (!st_r.beat && st_r.w_n == 2'h2)
                begin
                    st_nxt.beat      = 1'b1;
                    st_nxt.cnt       = st_r.w_coef - 4'h1;
                    st_nxt.mem_addr  = st_r.mem_addr + 24'h000001;
                    st_nxt.mem_wdata = {8'h00, st_r.hold[15:8]};
                end
                else
                begin
                    st_nxt.state    = dtc_pkg::DTC_IDLE;
                    st_nxt.mem_wr   = 1'b0;
                    st_nxt.mem_byte = 1'b0;
                    st_nxt.owns_bus = 1'b0;
                    st_nxt.need_cpu = 1'b1;
                end
            end
            default:
            begin
                st_nxt.state = dtc_pkg::DTC_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_r       <= '0;
            st_r.state <= dtc_pkg::DTC_IDLE;
            st_r.cfg   <= `DTC_CFG_RESET;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign prdata       = st_r.prdata;
    assign pready       = st_r.pready;
    assign pslverr      = st_r.pslverr;
    assign dma_owns_bus = st_r.owns_bus;
    assign mem_addr     = st_r.mem_addr;
    assign mem_rd       = st_r.mem_rd;
    assign mem_wr       = st_r.mem_wr;
    assign mem_byte     = st_r.mem_byte;
    assign mem_wdata    = st_r.mem_wdata;

endmodule

// ### test/dtc_core_monitor.sv
// Port checker of the transfer engine: bus handshake, beat order and CPU turns.
// Assumes it is bound onto dtc_core; core_clk rising edge, resetn active low.
module dtc_core_monitor (
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        cpu_access_done,
    input wire logic        ext_wait_hold,
    input wire logic        dma_owns_bus,
    input wire logic [23:0] mem_addr,
    input wire logic        mem_rd,
    input wire logic        mem_wr,
    input wire logic        mem_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic need_cpu_r;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // Set while the engine owns the bus, cleared by the next CPU access.
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            need_cpu_r <= 1'b0;
        else if (dma_owns_bus || cpu_access_done)
            need_cpu_r <= dma_owns_bus;
    end
    // The two phases of one register access.
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    a_apb_answer: assert property (s_setup ##1 s_access |=> pready)
        else $error("access not answered");
    a_pready_pulse: assert property (pready |=> !pready)
        else $error("pready too long");
    a_err_unmapped: assert property (pready && (paddr == 8'h0c || paddr > 8'h2c) |-> pslverr)
        else $error("unmapped without error");
    a_rd_wr_excl: assert property (!(mem_rd && mem_wr))
        else $error("read and write at once");
    a_wr_after_rd: assert property ($rose(mem_wr) |-> $past(mem_rd))
        else $error("write not after read");
    a_bus_owned: assert property ((mem_rd || mem_wr) |-> dma_owns_bus)
        else $error("cycle without ownership");
    a_own_bounded: assert property ($rose(dma_owns_bus) |-> ##[1:200] !dma_owns_bus)
        else $error("ownership not returned");
    a_cpu_between: assert property ($rose(dma_owns_bus) |-> !need_cpu_r)
        else $error("no CPU access between");
    a_split_next: assert property (((mem_rd && $past(mem_rd)) || (mem_wr && $past(mem_wr)))
        && mem_byte && $past(mem_byte) && mem_addr != $past(mem_addr)
        |-> mem_addr == $past(mem_addr) + 24'h1)
        else $error("byte halves not consecutive");
    a_ext_stretch: assert property (mem_rd && ext_wait_hold && mem_addr > 24'h00ffff
        |=> mem_rd && $stable(mem_addr))
        else $error("read not stretched");
endmodule

bind dtc_core dtc_core_monitor i_mon (.core_clk, .resetn, .psel, .penable, .paddr, .pready,
    .pslverr, .cpu_access_done, .ext_wait_hold, .dma_owns_bus, .mem_addr, .mem_rd, .mem_wr,
    .mem_byte);

// ### test/dtc_bus_partner.sv
// Behavioural CPU and memory far side of the transfer engine.
// Assumes the engine drives its bus outputs from flip-flops on rising core_clk.
module dtc_bus_partner (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        dma_owns_bus,
    input  wire logic [23:0] mem_addr,
    input  wire logic        mem_rd,
    input  wire logic        stretch_en,
    output logic             cpu_access_done,
    output logic             ext_wait_hold,
    output logic [15:0]      mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        owned_r;
    logic [1:0]  gap_r;
    logic [1:0]  hold_r;
    logic [15:0] pat_r;
    // Read data follows the address; the idle bus toggles.
    assign mem_rdata = mem_rd ? {~mem_addr[7:0], mem_addr[7:0]} : pat_r;
    // One CPU access after each transfer; a slow slave stretches external reads.
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            owned_r <= 1'b0;
            gap_r <= 2'h0;
            hold_r <= 2'h3;
            pat_r <= 16'h5a5a;
            cpu_access_done <= 1'b0;
            ext_wait_hold <= 1'b0;
        end
        else
        begin
            owned_r <= dma_owns_bus;
            pat_r <= ~pat_r;
            if (owned_r && !dma_owns_bus)
                gap_r <= 2'h2;
            else if (gap_r != 2'h0)
                gap_r <= gap_r - 2'h1;
            cpu_access_done <= (gap_r == 2'h1);
            ext_wait_hold <= stretch_en && mem_rd && mem_addr > 24'h00ffff && hold_r != 2'h0;
            if (!dma_owns_bus)
                hold_r <= 2'h3;
            else if (stretch_en && mem_rd && mem_addr > 24'h00ffff && hold_r != 2'h0)
                hold_r <= hold_r - 2'h1;
        end
    end
endmodule

// ### test/dtc_core_tb_top.sv
// Self-checking bench of the transfer engine: cycle counts, priority, CPU turns.
// Assumes the design, partner and bound checker are compiled first.
module dtc_core_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  dma_request = 4'h0;
    logic        stretch_en = 1'b0;
    logic [31:0] prdata, rd;
    logic [15:0] mem_rdata, mem_wdata, wd;
    logic [23:0] mem_addr;
    logic        pready, pslverr, cpu_access_done, ext_wait_hold, dma_owns_bus, err;
    logic        mem_rd, mem_wr, mem_byte;
    int          n_fail = 0;
    int          checked = 0;
    // Free-running 25 MHz clock.
    always #20 core_clk = ~core_clk;
    dtc_core i_dut (.core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .dma_request, .cpu_access_done, .ext_wait_hold, .mem_rdata,
        .dma_owns_bus, .mem_addr, .mem_rd, .mem_wr, .mem_byte, .mem_wdata);
    dtc_bus_partner i_mem (.core_clk, .resetn, .dma_owns_bus, .mem_addr, .mem_rd, .stretch_en,
        .cpu_access_done, .ext_wait_hold, .mem_rdata);
    // Prints the counts and the verdict, then stops.
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic fail(input string m);
        n_fail++;
        $display("mismatch at %0t: %s", $time, m);
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
        checked++;
        if (g !== e)
            fail(m);
    endtask
    // One APB transfer into rd and err.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge core_clk);
            if (pready === 1'b1)
                break;
        end
        if (i == 20)
        begin
            fail("apb timeout");
            complete_run();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Counts the read and write cycles of one transfer; keeps first address and write data.
    task automatic watch(output int nr, output int nw, output logic [23:0] a0);
        int i;
        bit on;
        nr = 0;
        nw = 0;
        on = 0;
        for (i = 0; i < 300; i++)
        begin
            @(posedge core_clk);
            if (dma_owns_bus === 1'b1)
            begin
                if (!on)
                    a0 = mem_addr;
                on = 1;
                nr += int'(mem_rd === 1'b1);
                if (mem_wr === 1'b1 && nw == 0)
                    wd = mem_wdata;
                nw += int'(mem_wr === 1'b1);
            end
            else if (on)
                break;
        end
        if (i == 300)
        begin
            fail("transfer timeout");
            complete_run();
        end
    endtask
    // Runs one software-requested transfer and judges it.
    task automatic run_case(input logic [1:0] ch, input logic [15:0] cfg, input logic [23:0] s,
                            input logic [23:0] d, input int cyc, input int er, input int ew);
        int          nr, nw;
        logic [23:0] a0;
        apb(1'b1, 8'h00, {16'h0, cfg});
        apb(1'b1, 8'h10 + {3'h0, ch, 3'h0}, {8'h0, s});
        apb(1'b1, 8'h14 + {3'h0, ch, 3'h0}, {8'h0, d});
        apb(1'b1, 8'h04, {28'h0, 4'h1 << ch});
        watch(nr, nw, a0);
        apb(1'b0, 8'h08, 32'h0);
        cmp(32'(nr), 32'(er), "read cycles");
        cmp(32'(nw), 32'(ew), "write cycles");
        cmp({24'h0, rd[15:8]}, 32'(cyc), "cycle count");
        cmp({30'h0, rd[7:6]}, {30'h0, ch}, "last channel");
        cmp({8'h0, a0}, {8'h0, s}, "source first");
    endtask
    task automatic t_regs();
        apb(1'b0, 8'h00, 32'h0);
        cmp(rd, 32'h2000, "cfg reset");
        apb(1'b0, 8'h0c, 32'h0);
        cmp({31'h0, err}, 32'h1, "unmapped error");
        cmp(rd, 32'h0, "unmapped data");
        apb(1'b1, 8'h2c, 32'h00abcdef);
        apb(1'b0, 8'h2c, 32'h0);
        cmp(rd, 32'h00abcdef, "address register");
    endtask
    task automatic t_internal();
        run_case(2'h0, 16'h2000, 24'h001000, 24'h002001, 2, 1, 1);
        run_case(2'h1, 16'h2020, 24'h001001, 24'h002000, 3, 2, 1);
        cmp({16'h0, wd}, 32'h0201, "write data");
        run_case(2'h0, 16'h2010, 24'h001000, 24'h002001, 3, 1, 2);
        run_case(2'h2, 16'h2000, 24'h000100, 24'h001000, 3, 2, 1);
        run_case(2'h3, 16'h2002, 24'h001000, 24'h002000, 4, 2, 2);
        run_case(2'h0, 16'h2010, 24'h400000, 24'h800000, 2, 1, 1);
    endtask
    task automatic t_external();
        run_case(2'h0, 16'h2011, 24'h400000, 24'h800000, 8, 4, 4);
        run_case(2'h0, 16'h2411, 24'h400000, 24'h800000, 6, 4, 2);
        run_case(2'h0, 16'h2211, 24'h400000, 24'h800000, 6, 2, 4);
        run_case(2'h0, 16'h3615, 24'h400000, 24'h800000, 8, 4, 4);
        run_case(2'h0, 16'h2001, 24'h400001, 24'h800000, 4, 2, 2);
    endtask
    task automatic t_stretch();
        stretch_en <= 1'b1;
        run_case(2'h0, 16'h2011, 24'h400000, 24'h800000, 8, 7, 4);
        stretch_en <= 1'b0;
    endtask
    // All request at once; channel 1 twice before its grant.
    task automatic t_priority();
        int          i, nr, nw;
        logic [23:0] a0;
        apb(1'b1, 8'h00, 32'h2000);
        for (i = 0; i < 4; i++)
            apb(1'b1, 8'(8'h10 + 8 * i), 32'h1000 + 32'(i));
        @(posedge core_clk);
        dma_request <= 4'hf;
        @(posedge core_clk);
        dma_request <= 4'h2;
        @(posedge core_clk);
        dma_request <= 4'h0;
        for (i = 0; i < 4; i++)
        begin
            watch(nr, nw, a0);
            cmp({8'h0, a0}, 32'h1000 + 32'(i), "grant order");
            cmp(32'(nr + nw), 32'h2, "one unit per grant");
        end
        apb(1'b0, 8'h08, 32'h0);
        cmp({28'h0, rd[3:0]}, 32'h0, "flags left");
    endtask
    initial
    begin
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        t_regs();
        t_internal();
        t_external();
        t_stretch();
        t_priority();
        complete_run();
    end
endmodule
